// ---- verif/testbench.sv ----
// testbench: drives tpg_gen over apb and checks its lane patterns.
// assumes tpg_pkg, tpg_gen, tpg_rx_model and tpg_gen_sva are compiled.
`timescale 1ns/100ps
module testbench;
  import tpg_pkg::*;
  localparam logic [7:0]  MODE = 8'h2A;
  localparam logic [95:0] RPT  = 96'hBED7_2347_6B8F_B314_5EFB_3559;
  localparam logic [63:0] W12  = 64'hE11E_12E1_3E14_E150;
  localparam int          TA[5] = '{6, 5, 14, 18, 28};
  localparam int          TB[5] = '{7, 9, 15, 23, 31};
  localparam logic [7:0]  CM[4] = '{8'h90, 8'h94, 8'hA0, 8'hA4};
  localparam logic [8:0]  EX[4] = '{9'h16A, 9'h16A, 9'h179, 9'h078};
  logic                   pclk, presetn, psel, penable, pwrite;
  logic                   power_down_pin, req_sync, slow, err;
  logic                   pready, pslverr, sh_fec, sh_crc12;
  logic                   cgs_req, ila_repeat, powered_down;
  logic                   sync_req_n, link_data_phase;
  logic [7:0]             paddr, link_mode_index, x, y;
  logic [31:0]            pwdata, prdata, q, w0, w1;
  logic [NLANE-1:0][7:0]  fmt_octet;
  tpg_lane_t [NLANE-1:0]  lane_out;
  logic [NLANE-1:0]       lane_tx_en;
  logic [7:0]             o0[40];
  int                     failures, compares, i, m;

  tpg_gen u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .power_down_pin, .link_data_phase,
    .sync_req_n, .fmt_octet, .lane_out, .lane_tx_en, .sh_fec, .sh_crc12,
    .link_mode_index, .cgs_req, .ila_repeat, .powered_down);
  tpg_rx_model u_rx (.pclk, .presetn, .lane_tx_en, .ila_repeat, .cgs_req,
    .req_sync, .slow, .sync_req_n, .link_data_phase);

  always #10 pclk = ~pclk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a hung wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // select with the link off first, then enable
  task automatic go(input logic [7:0] lo);
    apb(1'b1, ADDR_CTRL, {16'h0, MODE, lo});
    apb(1'b1, ADDR_CTRL, {16'h0, MODE, lo | 8'h01});
    repeat (12) @(negedge pclk);
  endtask
  task automatic wait_oct(input int ln, input logic [7:0] v);
    int n;
    n = 0;
    while (lane_out[ln].octet !== v && n < 200)
    begin
      @(negedge pclk);
      n++;
    end
    chk(lane_out[ln].octet, v);
  endtask
  function automatic logic bt(input int n);
    return o0[n / 8][7 - n % 8];
  endfunction
  task automatic give_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    power_down_pin = 0;
    req_sync = 0;
    slow = 0;
    fmt_octet = {NLANE{8'h3C}};
    failures = 0;
    compares = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk({sh_fec, sh_crc12}, 2'b01);
    apb(1'b0, ADDR_LINK, 0);
    chk(q, 32'h001F_FFFF);
    apb(1'b0, 8'h10, 0);
    chk({err, q[30:0]}, 32'h8000_0000);
    for (m = 0; m < 5; m++)
    begin
      go(8'(8'h10 * (m + 1)));
      for (i = 0; i < 40; i++)
      begin
        o0[i] = lane_out[0].octet;
        if (i < 4) w0 = {w0[23:0], o0[i]};
        if (i < 4) w1 = {w1[23:0], lane_out[1].octet};
        @(negedge pclk);
      end
      chk(lane_out[0].raw, 1);
      chk(w0 != w1, 1);
      chk(w0 != 0, 1);
      for (i = TB[m]; i < 320; i++)
        chk(bt(i), bt(i - TA[m]) ^ bt(i - TB[m]));
    end
    // fixed-octet modes, and the comma refused under 64b/66b
    for (m = 0; m < 4; m++)
    begin
      go(CM[m]);
      for (i = 0; i < NLANE; i++)
        chk({lane_out[i].octet, lane_out[i].is_k}, EX[m]);
      chk({link_mode_index, lane_tx_en}, {MODE, 16'hFFFF});
      apb(1'b0, ADDR_STAT, 0);
      chk(q[4:0], (m == 3) ? 5'h1B : 5'h0B);
    end
    go(8'h60);
    x = lane_out[3].octet;
    @(negedge pclk);
    chk({x ^ lane_out[3].octet, lane_out[3].raw}, 9'h1FF);
    chk(x == 8'hFF || x == 8'h00, 1);
    go(8'hC0);
    wait_oct(0, 8'hBE);
    for (i = 0; i < 24; i++)
    begin
      chk(lane_out[0].octet, RPT[95 - 8 * (i % 12) -: 8]);
      @(negedge pclk);
    end
    go(8'h80);
    x = lane_out[2].octet;
    @(negedge pclk);
    y = lane_out[2].octet;
    chk({x, y} == 16'h02FD || {x, y} == 16'hFD02, 1);
    chk(lane_out[10].octet, y);
    apb(1'b1, ADDR_LINK, 32'h0E1F_FFFF);
    go(8'h88);
    // sync on the unique tail octet; the word-head octet recurs
    wait_oct(1, 8'h50);
    @(negedge pclk);
    for (i = 0; i < 16; i++)
    begin
      chk(lane_out[1].octet, W12[63 - 8 * (i % 8) -: 8]);
      @(negedge pclk);
    end
    apb(1'b1, ADDR_LINK, 32'h001F_FFFF);
    slow <= 1'b1;
    go(8'h70);
    wait_oct(0, 8'h00);
    chk(link_data_phase, 1);
    for (i = 0; i < 33; i++)
    begin
      chk({lane_out[0].octet, lane_out[7].octet}, {2{8'(i % 32)}});
      @(negedge pclk);
    end
    go(8'hB0);
    @(posedge pclk) req_sync <= 1'b1;
    repeat (4) @(negedge pclk);
    chk({cgs_req, ila_repeat, link_data_phase}, 3'b110);
    @(posedge pclk) req_sync <= 1'b0;
    go(8'h90);
    apb(1'b1, ADDR_PWR, 32'h2);
    repeat (4) @(negedge pclk);
    chk(lane_tx_en, 16'hFF00);
    apb(1'b1, ADDR_PWR, 32'h1); // host powers the converter off
    repeat (4) @(negedge pclk);
    chk({powered_down, lane_tx_en}, 17'h10000);
    apb(1'b1, ADDR_PWR, 32'h0);
    @(posedge pclk) power_down_pin <= 1'b1;
    @(negedge pclk);
    chk({powered_down, lane_tx_en}, 17'h10000);
    @(posedge pclk) power_down_pin <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h2);
    repeat (3) @(negedge pclk);
    chk({sh_fec, sh_crc12}, 2'b10);
    give_verdict;
  end
  // watchdog: the whole sequence needs a few hundred cycles
  initial
  begin
    repeat (30000) @(posedge pclk);
    failures++;
    give_verdict;
  end
endmodule

// ---- verif/tpg_gen_sva.sv ----
// tpg_gen_sva: port-level checks of the test pattern generator.
// assumes it is bound onto tpg_gen and sees only its ports.
`timescale 1ns/100ps
module tpg_gen_sva
  import tpg_pkg::*;
(
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic                        power_down_pin,
  input wire logic                        sync_req_n,
  input wire tpg_lane_t [NLANE-1:0]       lane_out,
  input wire logic [NLANE-1:0]            lane_tx_en,
  input wire logic                        sh_fec,
  input wire logic                        sh_crc12,
  input wire logic [7:0]                  link_mode_index,
  input wire logic                        cgs_req,
  input wire logic                        ila_repeat,
  input wire logic                        powered_down
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic wctrl;
  // a completed ctrl write; link mode may only move after one
  assign wctrl = psel && penable && pwrite && paddr == ADDR_CTRL;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_sync; ila_repeat && !sync_req_n; endsequence
  sequence s_cgs; cgs_req; endsequence
  property p_crc; sh_crc12 != sh_fec; endproperty
  property p_pin; power_down_pin |-> lane_tx_en == '0 && powered_down;
  endproperty
  // registered enable needs one edge after the field is set
  property p_off; powered_down [*3] |-> lane_tx_en == '0; endproperty
  property p_mode;
    $changed(link_mode_index) |-> $past(wctrl) || $past(wctrl, 2);
  endproperty
  property p_cgs; s_sync |=> s_cgs; endproperty
  property p_cgs_src; s_cgs |-> !$past(sync_req_n); endproperty
  property p_raw; lane_out[0].raw |-> !lane_out[0].is_k; endproperty
  property p_k; lane_out[0].is_k |-> lane_out[0].octet == OCT_K285;
  endproperty
  a_crc: assert property (p_crc)
    else $error("crc and fec selected together");
  a_pin: assert property (p_pin)
    else $error("lane drivers on while pin high");
  a_off: assert property (p_off)
    else $error("lane drivers on while powered down");
  a_mode: assert property (p_mode)
    else $error("link mode moved without a write");
  a_cgs: assert property (p_cgs)
    else $error("sync request ignored in ila mode");
  a_cgs_src: assert property (p_cgs_src)
    else $error("code group sync without request");
  a_raw: assert property (p_raw)
    else $error("bypass octet marked as control");
  a_k: assert property (p_k)
    else $error("control octet is not the comma");
endmodule

bind tpg_gen tpg_gen_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .power_down_pin, .sync_req_n, .lane_out, .lane_tx_en, .sh_fec,
  .sh_crc12, .link_mode_index, .cgs_req, .ila_repeat, .powered_down);

// ---- verif/tpg_rx_model.sv ----
// tpg_rx_model: far-side receiver, raises sync and reports data phase.
// assumes lane_tx_en low means the link is down.
`timescale 1ns/100ps
module tpg_rx_model
  import tpg_pkg::*;
#(
  parameter int LAT = 4
)
(
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic [NLANE-1:0]            lane_tx_en,
  input wire logic                        ila_repeat,
  input wire logic                        cgs_req,
  input wire logic                        req_sync,
  input wire logic                        slow,
  output logic                            sync_req_n,
  output logic                            link_data_phase
);
  logic [7:0] cnt;
  logic       seen;
  // link bring-up; slow stretches the alignment four times
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt             <= 8'h00;
      seen            <= 1'b0;
      sync_req_n      <= 1'b1;
      link_data_phase <= 1'b0;
    end
    else
    begin
      sync_req_n <= !req_sync;
      seen       <= cgs_req;
      if (lane_tx_en == '0)
      begin
        cnt             <= 8'h00; // relink and flush after wake
        link_data_phase <= 1'b0;
      end
      else if (cnt < (slow ? 8'(4 * LAT) : 8'(LAT)))
        cnt <= cnt + 8'h01; // stale data discarded meanwhile
      else
        link_data_phase <= !ila_repeat && !seen; // ila never data
    end
endmodule

// ---- verilog/tpg_gen.sv ----
// tpg_gen: test pattern generator and sync-header mode control for the
// serial transmit lanes, with power-down gating of the lane drivers.
// assumes the link layer encodes/scrambles octets unless raw is set,
// and reports on link_data_phase when ILA or serializer init is done.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps

module tpg_gen
  import tpg_pkg::*;
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        power_down_pin,
  input  wire logic                        link_data_phase,
  input  wire logic                        sync_req_n,
  input  wire logic [tpg_pkg::NLANE-1:0][7:0] fmt_octet,
  output tpg_pkg::tpg_lane_t [tpg_pkg::NLANE-1:0] lane_out,
  output logic [tpg_pkg::NLANE-1:0]        lane_tx_en,
  output logic                             sh_fec,
  output logic                             sh_crc12,
  output logic [7:0]                       link_mode_index,
  output logic                             cgs_req,
  output logic                             ila_repeat,
  output logic                             powered_down
);
  import tpg_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // every flop of the block sits in this one struct
  tpg_state_t r_reg;
  tpg_state_t r_next;

  // ----------------------------------------------------------------
  // prbs: eight serial steps per octet, first bit in the msb
  // ----------------------------------------------------------------
  function automatic logic [38:0] prbs8(input logic [30:0] s_in,
                                        input tpg_test_t m);
    logic [30:0] s;
    logic [7:0]  b;
    logic        fb;
    s  = s_in;
    b  = OCT_ZERO;
    fb = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      case (m)
        TP_PRBS7:  fb = s[T7A] ^ s[T7B];
        TP_PRBS9:  fb = s[T9A] ^ s[T9B];
        TP_PRBS15: fb = s[T15A] ^ s[T15B];
        TP_PRBS23: fb = s[T23A] ^ s[T23B];
        TP_PRBS31: fb = s[T31A] ^ s[T31B];
        default:   fb = 1'b0;
      endcase
      s = {s[29:0], fb};
      b = {b[6:0], fb};
    end
    return {b, s};
  endfunction

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  // decode of the registered configuration, the pin and paddr, valid every cycle
  logic        pd;
  logic        only8;
  logic        bad_mode;
  logic        bypass;
  logic        is_prbs;
  logic        hit;
  logic        frame_end;
  logic [31:0] rd_val;
  // scratch shared by the per-lane loop, cleared at the top of the next-state block
  logic [38:0] pr;
  logic [63:0] w12;
  logic [3:0]  li;
  logic [7:0]  val;

  // mode classes
  always_comb
  begin
    pd       = power_down_pin | r_reg.pwr_off;
    is_prbs  = (r_reg.sel >= TP_PRBS7) && (r_reg.sel <= TP_PRBS31);
    only8    = (r_reg.sel == TP_K285) || (r_reg.sel == TP_ILA) ||
               (r_reg.sel == TP_RPAT);
    // 8b/10b-only patterns are refused on a 64b/66b link
    bad_mode = only8 && r_reg.enc64;
    // these never wait for the link layer to finish alignment
    bypass   = is_prbs || (r_reg.sel == TP_CLOCK) ||
               (r_reg.sel == TP_D215) || (r_reg.sel == TP_K285);
    hit      = (paddr == ADDR_CTRL) || (paddr == ADDR_LINK) ||
               (paddr == ADDR_PWR) || (paddr == ADDR_STAT);
    frame_end = (r_reg.oct == r_reg.fm1);
  end

  // read mux
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL:
      begin
        rd_val[CTRL_EN_BIT]    = r_reg.link_en;
        rd_val[CTRL_FEC_BIT]   = r_reg.fec;
        rd_val[CTRL_ENC64_BIT] = r_reg.enc64;
        rd_val[CTRL_N12_BIT]   = r_reg.n12;
        rd_val[CTRL_SEL_LSB +: 4]  = r_reg.sel;
        rd_val[CTRL_MODE_LSB +: 8] = r_reg.mode_idx;
      end
      ADDR_LINK:
      begin
        rd_val[LINK_LANE_LSB +: NLANE] = r_reg.lane_en;
        rd_val[LINK_KM1_LSB +: 9]      = r_reg.km1;
        rd_val[LINK_FM1_LSB +: 4]      = r_reg.fm1;
      end
      ADDR_PWR:
      begin
        rd_val[PWR_OFF_BIT] = r_reg.pwr_off;
        rd_val[PWR_PDA_BIT] = r_reg.pd_a;
        rd_val[PWR_PDB_BIT] = r_reg.pd_b;
      end
      ADDR_STAT:
        // run state, pin, any driver on, refused mode
        rd_val[4:0] = {bad_mode, |r_reg.tx_en, power_down_pin,
                       r_reg.run};
      default:
        rd_val = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    pr     = 39'h0;
    w12    = 64'h0;
    li     = 4'h0;
    val    = OCT_ZERO;

    // apb: read data is captured in the setup cycle
    if (psel && !penable && !pwrite)
      r_next.prdata = rd_val;
    // writes land at the access edge; unmapped ones change nothing
    if (psel && penable && pwrite)
    begin
      case (paddr)
        ADDR_CTRL:
        begin
          r_next.link_en  = pwdata[CTRL_EN_BIT];
          r_next.fec      = pwdata[CTRL_FEC_BIT];
          r_next.enc64    = pwdata[CTRL_ENC64_BIT];
          r_next.n12      = pwdata[CTRL_N12_BIT];
          r_next.mode_idx = pwdata[CTRL_MODE_LSB +: 8];
          // selection frozen while the link runs
          if (!r_reg.link_en)
            r_next.sel = tpg_test_t'(pwdata[CTRL_SEL_LSB +: 4]);
        end
        ADDR_LINK:
        begin
          r_next.lane_en = pwdata[LINK_LANE_LSB +: NLANE];
          r_next.km1     = pwdata[LINK_KM1_LSB +: 9];
          r_next.fm1     = pwdata[LINK_FM1_LSB +: 4];
        end
        ADDR_PWR:
        begin
          r_next.pwr_off = pwdata[PWR_OFF_BIT];
          r_next.pd_a    = pwdata[PWR_PDA_BIT];
          r_next.pd_b    = pwdata[PWR_PDB_BIT];
        end
        default:
          r_next.prdata = r_reg.prdata;
      endcase
    end

    // run sequencer: idle, wait for alignment, data
    case (r_reg.run)
      RUN_IDLE:
        if (r_reg.link_en && !pd)
        begin
          r_next.run = RUN_WAIT;
          // distinct nonzero seeds: no lane shares a phase or locks up
          for (int l = 0; l < NLANE; l++)
            r_next.prbs[l] = SEED_BASE + 31'(l);
        end
      RUN_WAIT:
        if (!r_reg.link_en || pd)
          r_next.run = RUN_IDLE;
        else if (bypass || link_data_phase)
          r_next.run = RUN_DATA;
      RUN_DATA:
        if (!r_reg.link_en || pd)
          r_next.run = RUN_IDLE;
      default:
        r_next.run = RUN_IDLE;
    endcase

    // frame, multiframe and pattern counters
    if (r_reg.run != RUN_DATA)
    begin
      r_next.oct    = 4'h0;
      r_next.frm    = 9'h000;
      r_next.odd    = 1'b0;
      r_next.ramp   = OCT_ZERO;
      r_next.rpat   = 4'h0;
      r_next.clk_hi = 1'b1;
    end
    else
    begin
      r_next.oct    = frame_end ? 4'h0 : r_reg.oct + 4'h1;
      r_next.clk_hi = ~r_reg.clk_hi;
      r_next.rpat   = (r_reg.rpat == RPAT_LAST) ? 4'h0
                                                : r_reg.rpat + 4'h1;
      // ramp wraps past 0xFF by its own width
      r_next.ramp   = r_reg.ramp + 8'h01;
      // frame parity selects between the two 8-bit pattern frames
      if (frame_end)
      begin
        r_next.odd = ~r_reg.odd;
        if (r_reg.frm == r_reg.km1)
        begin
          r_next.frm  = 9'h000;
          r_next.ramp = OCT_ZERO;
        end
        else
          r_next.frm = r_reg.frm + 9'h001;
      end
    end

    // per-lane octet selection
    for (int l = 0; l < NLANE; l++)
    begin
      li  = 4'(l % GRP);
      pr  = prbs8(r_reg.prbs[l], r_reg.sel);
      // five 12-bit words then the tail nibble, msb octet first
      w12 = {NIB_MAX - li, li, 4'h1, NIB_MAX - li, li, 4'h2,
             NIB_MAX - li, li, 4'h3, NIB_MAX - li, li, 4'h4,
             NIB_MAX - li, li, 4'h5, NIB_TAIL};
      // formatter data passes unless a test pattern owns the lane
      r_next.lane[l].octet = fmt_octet[l];
      r_next.lane[l].is_k  = 1'b0;
      r_next.lane[l].raw   = 1'b0;
      // refused modes keep formatter data; the fault shows in status
      if (r_reg.run == RUN_DATA && !bad_mode)
      begin
        case (r_reg.sel)
          TP_PRBS7, TP_PRBS9, TP_PRBS15, TP_PRBS23, TP_PRBS31:
          begin
            r_next.prbs[l]       = pr[30:0];
            r_next.lane[l].octet = pr[38:31];
            r_next.lane[l].raw   = 1'b1;
          end
          // clk_hi flips each octet: eight ones, then eight zeros
          TP_CLOCK:
          begin
            r_next.lane[l].octet = r_reg.clk_hi ? OCT_ONES
                                                : OCT_ZERO;
            r_next.lane[l].raw   = 1'b1;
          end
          TP_RAMP:
            r_next.lane[l].octet = r_reg.ramp;
          TP_SHORT:
          begin
            val = {4'h0, li};
            if (r_reg.n12)
              r_next.lane[l].octet = w12[8*(7 - (r_reg.oct % 8)) +: 8];
            else
              r_next.lane[l].octet = r_reg.odd ? OCT_ONES - val
                                               : val;
          end
          TP_D215:
            r_next.lane[l].octet = OCT_D215;
          TP_K285:
          begin
            r_next.lane[l].octet = OCT_K285;
            r_next.lane[l].is_k  = 1'b1;
          end
          TP_RPAT:
            r_next.lane[l].octet =
              RPAT_TBL[8*(RPAT_LEN - 1 - r_reg.rpat) +: 8];
          default:
            r_next.lane[l].octet = fmt_octet[l];
        endcase
      end
    end

    // driver enables follow the link mode lanes, not the test
    for (int l = 0; l < NLANE; l++)
      r_next.tx_en[l] = r_reg.lane_en[l] && r_reg.link_en && !pd &&
                        !((l < GRP) ? r_reg.pd_a : r_reg.pd_b);

    // each sync request restarts code group sync in ila mode
    r_next.cgs_req = (r_reg.sel == TP_ILA) && !bad_mode &&
                     (r_reg.run != RUN_IDLE) && !sync_req_n;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    // constants only here; nonzero resets come from the package, except clk_hi
    if (!presetn)
    begin
      r_reg          <= '0;
      r_reg.sel      <= TP_OFF;
      r_reg.run      <= RUN_IDLE;
      r_reg.lane_en  <= RST_LANE_EN;
      r_reg.km1      <= RST_KM1;
      r_reg.fm1      <= RST_FM1;
      r_reg.mode_idx <= RST_MODE;
      r_reg.clk_hi   <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero-wait slave: a defined error on unmapped addresses
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !hit;
  assign prdata          = r_reg.prdata;
  assign lane_out        = r_reg.lane;
  // pin gates drivers without a register stage for immediate shutoff
  assign lane_tx_en      = r_reg.tx_en & {NLANE{~power_down_pin}};
  assign sh_fec          = r_reg.fec;
  // checksum mode is the 12-bit crc whenever fec is off; no 3-bit variant exists
  assign sh_crc12        = ~r_reg.fec;
  // lane count and rate follow the mode index, never the test
  assign link_mode_index = r_reg.mode_idx;
  assign cgs_req         = r_reg.cgs_req;
  // link layer keeps replaying alignment while this is high
  assign ila_repeat      = (r_reg.sel == TP_ILA) && !bad_mode;
  assign powered_down    = pd;

endmodule

// ---- verilog/tpg_pkg.sv ----
// tpg_pkg: constants and types for the serial-link test pattern generator.
// assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
package tpg_pkg;

  localparam int NLANE = 16;          // lanes 0-7 group a, 8-15 group b
  localparam int GRP   = 8;           // lanes per group

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LINK = 8'h04;
  localparam logic [7:0] ADDR_PWR  = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;

  // ctrl fields
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_FEC_BIT   = 1;
  localparam int CTRL_ENC64_BIT = 2;
  localparam int CTRL_N12_BIT   = 3;
  localparam int CTRL_SEL_LSB   = 4;
  localparam int CTRL_MODE_LSB  = 8;
  // link fields
  localparam int LINK_LANE_LSB  = 0;
  localparam int LINK_KM1_LSB   = 16;
  localparam int LINK_FM1_LSB   = 25;
  // power fields
  localparam int PWR_OFF_BIT    = 0;
  localparam int PWR_PDA_BIT    = 1;
  localparam int PWR_PDB_BIT    = 2;

  // reset values
  localparam logic [15:0] RST_LANE_EN = 16'hFFFF;
  localparam logic [8:0]  RST_KM1     = 9'h01F;
  localparam logic [3:0]  RST_FM1     = 4'h0;
  localparam logic [7:0]  RST_MODE    = 8'h00;

  // ----------------------------------------------------------------
  // pattern constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  OCT_D215 = 8'hB5;
  localparam logic [7:0]  OCT_K285 = 8'hBC;
  localparam logic [7:0]  OCT_ONES = 8'hFF;
  localparam logic [7:0]  OCT_ZERO = 8'h00;
  localparam logic [3:0]  NIB_MAX  = 4'hF;
  localparam logic [3:0]  NIB_TAIL = 4'h0;
  localparam int          RPAT_LEN = 12;
  localparam logic [3:0]  RPAT_LAST = 4'hB;
  localparam logic [95:0] RPAT_TBL =
    96'hBED7_2347_6B8F_B314_5EFB_3559;
  localparam logic [30:0] SEED_BASE = 31'h0000_0001;

  // prbs tap indices (bit n-a sits at state index a-1)
  localparam int T7A  = 5;  localparam int T7B  = 6;
  localparam int T9A  = 4;  localparam int T9B  = 8;
  localparam int T15A = 13; localparam int T15B = 14;
  localparam int T23A = 17; localparam int T23B = 22;
  localparam int T31A = 27; localparam int T31B = 30;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TP_OFF    = 4'h0, TP_PRBS7 = 4'h1, TP_PRBS9 = 4'h2,
    TP_PRBS15 = 4'h3, TP_PRBS23 = 4'h4, TP_PRBS31 = 4'h5,
    TP_CLOCK  = 4'h6, TP_RAMP  = 4'h7, TP_SHORT = 4'h8,
    TP_D215   = 4'h9, TP_K285  = 4'hA, TP_ILA   = 4'hB,
    TP_RPAT   = 4'hC
  } tpg_test_t;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00, RUN_WAIT = 2'b01, RUN_DATA = 2'b11
  } tpg_run_t;

  typedef struct packed {
    logic [7:0] octet;
    logic       is_k;
    logic       raw;
  } tpg_lane_t;

  typedef struct packed {
    logic                          link_en;
    logic                          fec;
    logic                          enc64;
    logic                          n12;
    tpg_test_t                     sel;
    logic [7:0]                    mode_idx;
    logic [NLANE-1:0]              lane_en;
    logic [8:0]                    km1;
    logic [3:0]                    fm1;
    logic                          pwr_off;
    logic                          pd_a;
    logic                          pd_b;
    tpg_run_t                      run;
    logic [3:0]                    oct;
    logic [8:0]                    frm;
    logic                          odd;
    logic [7:0]                    ramp;
    logic [3:0]                    rpat;
    logic                          clk_hi;
    logic [NLANE-1:0][30:0]        prbs;
    logic [31:0]                   prdata;
    tpg_lane_t [NLANE-1:0]         lane;
    logic [NLANE-1:0]              tx_en;
    logic                          cgs_req;
  } tpg_state_t;

endpackage
